//--- logic/vrc_ref_control.sv
// Reference control register and the enables it drives into the analog circuits
// How it works
// R01: Source bit picks reference pin or supply
// R02: Bias generator auto-on for dependent peripherals
// R03: Bias enable bit forces bias generator on
// R04: Buffer enable bit drives reference onto pin
// R05: Software clears buffer enable when unused
// R06: Level bit selects 1.5 V or 2.20 V
// R07: Zero-TC bit forces bias on, else demand
// R08: Software sets zero-TC bit before oscillator suspend; here software writes cannot set it, only the hardware load port does
// R09: Sensor enable bit powers temperature sensor
// R10: Upper two bits read zero, ignore writes
// R11: Supply reference with converter blocks open-drain pin
// R12: Processor writes to read-only fields ignored
`timescale 1ns/1ps
`default_nettype none
module vrc_ref_control
  import vrc_pkg::*;
(
  input  wire logic            clk_sys_in,
  input  wire logic            rst_b_in,
  input  wire vrc_sfr_req_type sfr_req_in,
  input  wire logic            hw_load_in,
  input  wire logic [7:0]      hw_data_in,
  input  wire logic            converter_enable_in,
  input  wire logic            osc_bias_req_in,
  input  wire logic            zero_tc_demand_in,
  input  wire logic            port0_line0_od_req_in,
  output var  logic [7:0]      sfr_rdata_out,
  output var  vrc_analog_type  analog_out,
  output var  logic [11:0]     ref_level_mv_out,
  output var  logic            port0_line0_od_en_out,
  output var  logic            port0_line0_od_block_out
);

  logic [7:0]     reference_control;
  logic           ctrl_hit;
  logic           ctrl_wr;
  logic [7:0]     next_rdata;
  vrc_analog_type next_analog;
  logic [11:0]    next_level_mv;
  logic           next_od_block;
  logic           next_od_en;

  // Address decode for the one register of this block
  assign ctrl_hit = (sfr_req_in.addr == VRC_REF_CTRL_ADDR);
  assign ctrl_wr  = sfr_req_in.wr && ctrl_hit;

  // R12: read-only masking
  // R10: upper bits fixed
  vrc_field_reg #(
    .SW_MASK   (VRC_SW_WRITE_MASK),
    .HW_MASK   (VRC_HW_LOAD_MASK),
    .RESET_VAL (VRC_REF_CTRL_RESET)
  ) u_ctrl_reg (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .sw_wr_in   (ctrl_wr),
    .sw_data_in (sfr_req_in.wdata),
    .hw_load_in (hw_load_in),
    .hw_data_in (hw_data_in),
    .value_out  (reference_control)
  );

  // Read data; other addresses read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_req_in.rd && ctrl_hit) begin
      next_rdata = reference_control;
    end
  end

  // Analog enables and pin control derived from the register
  always_comb begin
    // R01: reference source route
    next_analog.ref_source_select  = reference_control[VRC_BIT_REF_SOURCE_SELECT];
    next_analog.ref_level_select   = reference_control[VRC_BIT_REF_LEVEL_SELECT];
    // R07: zero-TC force or demand
    next_analog.zero_tc_bias_on    = reference_control[VRC_BIT_ZERO_TC_BIAS_FORCE] | zero_tc_demand_in;
    // R09: temperature sensor power
    next_analog.temp_sensor_enable = reference_control[VRC_BIT_TEMP_SENSOR_ENABLE];
    // R02: automatic bias enable
    // R03: manual bias force
    next_analog.bias_gen_on        = reference_control[VRC_BIT_BIAS_GEN_ENABLE]
                                   | converter_enable_in
                                   | reference_control[VRC_BIT_TEMP_SENSOR_ENABLE]
                                   | osc_bias_req_in;
    // R04: reference output buffer
    next_analog.ref_buffer_enable  = reference_control[VRC_BIT_REF_BUFFER_ENABLE];
    // R06: level in millivolts
    next_level_mv = reference_control[VRC_BIT_REF_LEVEL_SELECT] ? VRC_REF_HIGH_MV : VRC_REF_LOW_MV;
    // R11: open-drain blocked on shared pin
    next_od_block = reference_control[VRC_BIT_REF_SOURCE_SELECT] & converter_enable_in;
    next_od_en    = port0_line0_od_req_in & ~next_od_block;
  end

  // Output registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sfr_rdata_out            <= 8'h00;
      analog_out               <= '0;
      ref_level_mv_out         <= VRC_REF_LOW_MV;
      port0_line0_od_block_out <= 1'h0;
      port0_line0_od_en_out    <= 1'h0;
    end else begin
      sfr_rdata_out            <= next_rdata;
      analog_out               <= next_analog;
      ref_level_mv_out         <= next_level_mv;
      port0_line0_od_block_out <= next_od_block;
      port0_line0_od_en_out    <= next_od_en;
    end
  end

  // Checks on the block's own behaviour
  default clocking vrc_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  // R01: source select check
  ref_source_route_a: assert property (ctrl_wr && !hw_load_in |-> ##2 // R01
    analog_out.ref_source_select == $past(sfr_req_in.wdata[VRC_BIT_REF_SOURCE_SELECT], 2))
    else $error("reference source select does not follow the write");

  // R02: automatic bias check
  bias_auto_on_a: assert property ((converter_enable_in || osc_bias_req_in // R02
    || reference_control[VRC_BIT_TEMP_SENSOR_ENABLE]) |=> analog_out.bias_gen_on)
    else $error("bias generator not on while a dependent peripheral is enabled");

  // R03: manual bias check
  bias_manual_a: assert property ((!converter_enable_in && !osc_bias_req_in // R03
    && !reference_control[VRC_BIT_TEMP_SENSOR_ENABLE]) |=>
    analog_out.bias_gen_on == $past(reference_control[VRC_BIT_BIAS_GEN_ENABLE]))
    else $error("bias generator does not follow its enable bit");

  // R04: buffer enable check
  ref_buffer_a: assert property (ctrl_wr && !hw_load_in |-> ##2 // R04
    analog_out.ref_buffer_enable == $past(sfr_req_in.wdata[VRC_BIT_REF_BUFFER_ENABLE], 2))
    else $error("reference buffer does not follow the write");

  // R06: output level check
  ref_level_a: assert property (1'h1 |=> ref_level_mv_out == // R06
    ($past(reference_control[VRC_BIT_REF_LEVEL_SELECT]) ? VRC_REF_HIGH_MV : VRC_REF_LOW_MV))
    else $error("reference level does not match the level bit");

  // R07: zero-TC bias check
  zero_tc_on_a: assert property ((reference_control[VRC_BIT_ZERO_TC_BIAS_FORCE] // R07
    || zero_tc_demand_in) |=> analog_out.zero_tc_bias_on)
    else $error("zero-TC bias not on when forced or demanded");

  // R09: temperature sensor check
  temp_sensor_a: assert property (ctrl_wr && !hw_load_in |-> ##2 // R09
    analog_out.temp_sensor_enable == $past(sfr_req_in.wdata[VRC_BIT_TEMP_SENSOR_ENABLE], 2))
    else $error("temperature sensor enable does not follow the write");

  // R10: upper bits check
  upper_bits_zero_a: assert property (sfr_req_in.rd && ctrl_hit |=> sfr_rdata_out[7:6] == 2'h0) // R10
    else $error("unused upper bits read nonzero");

  // R11: open-drain block check
  od_blocked_a: assert property (reference_control[VRC_BIT_REF_SOURCE_SELECT] // R11
    && converter_enable_in |=> !port0_line0_od_en_out && port0_line0_od_block_out)
    else $error("open-drain allowed on shared pin with supply reference");

  // R12: read-only fields check
  ro_fields_held_a: assert property (ctrl_wr && !hw_load_in |=> // R12
    reference_control[5:4] == $past(reference_control[5:4]))
    else $error("processor write changed a read-only field");

  // R10: read data mirrors the register
  read_back_a: assert property (sfr_req_in.rd && ctrl_hit |=> // R10
    sfr_rdata_out == $past(reference_control))
    else $error("read data does not match the register");

  // R10: read data idle at zero
  read_idle_zero_a: assert property (!(sfr_req_in.rd && ctrl_hit) |=> // R10
    sfr_rdata_out == 8'h00)
    else $error("read data nonzero without a read of this register");

  // R12: writable fields take the write
  sw_write_land_a: assert property (ctrl_wr |=> // R12
    reference_control[3:0] == $past(sfr_req_in.wdata[3:0]))
    else $error("processor write did not reach the writable fields");

  // R08: hardware load of read-only fields
  hw_load_land_a: assert property (hw_load_in |=> // R08
    reference_control[5:4] == $past(hw_data_in[5:4]))
    else $error("hardware load did not reach the read-only fields");

  // R07: zero-TC bias off when idle
  zero_tc_off_a: assert property (!reference_control[VRC_BIT_ZERO_TC_BIAS_FORCE] // R07
    && !zero_tc_demand_in |=> !analog_out.zero_tc_bias_on)
    else $error("zero-TC bias on while neither forced nor demanded");

  // R04: buffer follows its bit
  buffer_follow_a: assert property (1'h1 |=> analog_out.ref_buffer_enable // R04
    == $past(reference_control[VRC_BIT_REF_BUFFER_ENABLE]))
    else $error("reference buffer does not follow its enable bit");

  // R06: level bit to analog side
  level_bit_a: assert property (1'h1 |=> analog_out.ref_level_select // R06
    == $past(reference_control[VRC_BIT_REF_LEVEL_SELECT]))
    else $error("reference level select does not follow its bit");

  // R01: source select follows its bit
  source_follow_a: assert property (1'h1 |=> analog_out.ref_source_select // R01
    == $past(reference_control[VRC_BIT_REF_SOURCE_SELECT]))
    else $error("reference source select does not follow its bit");

  // R09: sensor power follows its bit
  sensor_follow_a: assert property (1'h1 |=> analog_out.temp_sensor_enable // R09
    == $past(reference_control[VRC_BIT_TEMP_SENSOR_ENABLE]))
    else $error("temperature sensor enable does not follow its bit");

  // R11: open-drain passed when unblocked
  od_passed_a: assert property (!(reference_control[VRC_BIT_REF_SOURCE_SELECT] // R11
    && converter_enable_in) |=> !port0_line0_od_block_out
    && port0_line0_od_en_out == $past(port0_line0_od_req_in))
    else $error("open-drain request not passed on an unblocked pin");

  // Main scenarios
  buffer_on_c: cover property (ctrl_wr && sfr_req_in.wdata[VRC_BIT_REF_BUFFER_ENABLE] ##2 analog_out.ref_buffer_enable);
  auto_bias_c: cover property (converter_enable_in && !reference_control[VRC_BIT_BIAS_GEN_ENABLE]
    ##1 analog_out.bias_gen_on);
  od_block_c:  cover property (port0_line0_od_req_in && next_od_block ##1 port0_line0_od_block_out);
  level_hi_c:  cover property (hw_load_in && hw_data_in[VRC_BIT_REF_LEVEL_SELECT] ##2 ref_level_mv_out == VRC_REF_HIGH_MV);
  bias_manual_c: cover property (ctrl_wr && sfr_req_in.wdata[VRC_BIT_BIAS_GEN_ENABLE] && !converter_enable_in
    ##2 analog_out.bias_gen_on);

endmodule : vrc_ref_control
`default_nettype wire

//--- common/vrc_pkg.sv
// Package for the voltage reference control block: register map, fields and carriers
package vrc_pkg;

  // Register map and reset value
  localparam logic [7:0] VRC_REF_CTRL_ADDR  = 8'hd1;
  localparam logic [7:0] VRC_REF_CTRL_RESET = 8'h00;

  // Field positions inside reference_control
  localparam int VRC_BIT_REF_BUFFER_ENABLE  = 0;
  localparam int VRC_BIT_BIAS_GEN_ENABLE    = 1;
  localparam int VRC_BIT_TEMP_SENSOR_ENABLE = 2;
  localparam int VRC_BIT_REF_SOURCE_SELECT  = 3;
  localparam int VRC_BIT_REF_LEVEL_SELECT   = 4;
  localparam int VRC_BIT_ZERO_TC_BIAS_FORCE = 5;

  // Bits that software may write, and bits that only the hardware load port sets
  localparam logic [7:0] VRC_SW_WRITE_MASK = 8'h0f;
  localparam logic [7:0] VRC_HW_LOAD_MASK  = 8'h30;

  // Reference output levels in millivolts
  localparam logic [11:0] VRC_REF_LOW_MV  = 12'h5dc;  // 1500 mV
  localparam logic [11:0] VRC_REF_HIGH_MV = 12'h898;  // 2200 mV

  // Special-function-register access from the processor
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } vrc_sfr_req_type;

  // Control lines to the analog reference, bias and sensor circuits
  typedef struct packed {
    logic ref_source_select;
    logic ref_level_select;
    logic zero_tc_bias_on;
    logic temp_sensor_enable;
    logic bias_gen_on;
    logic ref_buffer_enable;
  } vrc_analog_type;

endpackage : vrc_pkg

//--- logic/vrc_field_reg.sv
// Register with separate software-writable and hardware-loadable bit masks
`timescale 1ns/1ps
`default_nettype none
module vrc_field_reg #(
  parameter logic [7:0] SW_MASK   = 8'h00,
  parameter logic [7:0] HW_MASK   = 8'h00,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  input  wire logic       sw_wr_in,
  input  wire logic [7:0] sw_data_in,
  input  wire logic       hw_load_in,
  input  wire logic [7:0] hw_data_in,
  output var  logic [7:0] value_out
);

  logic [7:0] next_value;

  // Merge writes; bits outside both masks hold their reset value
  always_comb begin
    next_value = value_out;
    if (sw_wr_in) begin
      next_value = (next_value & ~SW_MASK) | (sw_data_in & SW_MASK);
    end
    if (hw_load_in) begin
      next_value = (next_value & ~HW_MASK) | (hw_data_in & HW_MASK);
    end
  end

  // Storage
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      value_out <= RESET_VAL;
    end else begin
      value_out <= next_value;
    end
  end

endmodule : vrc_field_reg
`default_nettype wire

//--- bench/tb.sv
// Self-checking testbench for the reference control register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vrc_pkg::*;
  logic            clk_sys_in;
  logic            rst_b_in;
  vrc_sfr_req_type sfr_req_in;
  logic            hw_load_in;
  logic [7:0]      hw_data_in;
  logic            conv_en;
  logic            osc_req;
  logic            ztc_dem;
  logic            od_req;
  logic [7:0]      rdata;
  vrc_analog_type  analog;
  logic [11:0]     level_mv;
  logic            od_en;
  logic            od_block;
  logic [7:0]      v;
  int              mismatches;
  int              num_checks;
  int              cycles;

  vrc_ref_control i_vrc_ref_control (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sfr_req_in(sfr_req_in),
    .hw_load_in(hw_load_in), .hw_data_in(hw_data_in), .converter_enable_in(conv_en),
    .osc_bias_req_in(osc_req), .zero_tc_demand_in(ztc_dem), .port0_line0_od_req_in(od_req),
    .sfr_rdata_out(rdata), .analog_out(analog), .ref_level_mv_out(level_mv),
    .port0_line0_od_en_out(od_en), .port0_line0_od_block_out(od_block));

  // Clock at 20 MHz
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // Timeout ceiling on clock cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  // Compare and count
  task check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Register bus cycles, driven just after the edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req_in.addr = a;
    sfr_req_in.wdata = d;
    sfr_req_in.wr = 1'b1;
    @(posedge clk_sys_in) #5 sfr_req_in.wr = 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    sfr_req_in.addr = a;
    sfr_req_in.rd = 1'b1;
    @(posedge clk_sys_in) #5 sfr_req_in.rd = 1'b0;
    v = rdata;
  endtask : rd

  task hw(input logic [7:0] d);
    hw_data_in = d;
    hw_load_in = 1'b1;
    @(posedge clk_sys_in) #5 hw_load_in = 1'b0;
  endtask : hw

  task settle();
    repeat (2) @(posedge clk_sys_in);
    #5;
  endtask : settle

  // Reset values, write masks and unmapped address
  task s_regs();
    rd(VRC_REF_CTRL_ADDR);
    check("reset", {4'h0, v}, {4'h0, VRC_REF_CTRL_RESET});
    wr(VRC_REF_CTRL_ADDR, 8'hff);
    settle();
    rd(VRC_REF_CTRL_ADDR);
    check("masked", {4'h0, v}, 12'h00f);
    check("analog", {6'h0, analog}, 12'h027);
    wr(VRC_REF_CTRL_ADDR, 8'h00);
    settle();
    check("cleared", {6'h0, analog}, 12'h000);
    wr(8'hd2, 8'h0f);
    rd(8'hd2);
    check("unmapped", {4'h0, v}, 12'h000);
    @(posedge clk_sys_in) #5;
    rd(VRC_REF_CTRL_ADDR);
    check("other", {4'h0, v}, 12'h000);
  endtask : s_regs

  // Automatic bias demand from each dependent peripheral
  task s_bias();
    conv_en = 1'b1;
    settle();
    check("bias conv", {11'h0, analog.bias_gen_on}, 12'h001);
    conv_en = 1'b0;
    osc_req = 1'b1;
    settle();
    check("bias osc", {11'h0, analog.bias_gen_on}, 12'h001);
    osc_req = 1'b0;
    wr(VRC_REF_CTRL_ADDR, 8'h04);
    settle();
    check("bias temp", {6'h0, analog}, 12'h006);
    wr(VRC_REF_CTRL_ADDR, 8'h02);
    settle();
    check("bias manual", {6'h0, analog}, 12'h002);
    wr(VRC_REF_CTRL_ADDR, 8'h00);
    settle();
    check("bias off", {11'h0, analog.bias_gen_on}, 12'h000);
  endtask : s_bias

  // Level select and zero-TC force loaded by hardware
  task s_level();
    hw(8'hdf);
    settle();
    rd(VRC_REF_CTRL_ADDR);
    check("hw load", {4'h0, v}, 12'h010);
    check("mv high", level_mv, VRC_REF_HIGH_MV);
    check("level bit", {11'h0, analog.ref_level_select}, 12'h001);
    check("ztc idle", {11'h0, analog.zero_tc_bias_on}, 12'h000);
    ztc_dem = 1'b1;
    settle();
    check("ztc demand", {11'h0, analog.zero_tc_bias_on}, 12'h001);
    ztc_dem = 1'b0;
    hw(8'h20);
    settle();
    check("mv low", level_mv, VRC_REF_LOW_MV);
    check("ztc force", {11'h0, analog.zero_tc_bias_on}, 12'h001);
  endtask : s_level

  // Open-drain blocking on the shared pin
  task s_od();
    wr(VRC_REF_CTRL_ADDR, 8'h08);
    conv_en = 1'b1;
    od_req = 1'b1;
    settle();
    check("od blocked", {10'h0, od_block, od_en}, 12'h002);
    conv_en = 1'b0;
    settle();
    check("od conv off", {10'h0, od_block, od_en}, 12'h001);
    wr(VRC_REF_CTRL_ADDR, 8'h00);
    conv_en = 1'b1;
    settle();
    check("od pin ref", {10'h0, od_block, od_en}, 12'h001);
  endtask : s_od

  // Verdict and end of run
  task wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    rst_b_in = 1'b0;
    sfr_req_in = '0;
    hw_load_in = 1'b0;
    hw_data_in = 8'h00;
    {conv_en, osc_req, ztc_dem, od_req} = 4'h0;
    repeat (16) @(posedge clk_sys_in);
    #5 rst_b_in = 1'b1;
    @(posedge clk_sys_in) #5;
    s_regs();
    s_bias();
    s_level();
    s_od();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
